// >>> sab_map.vh
// Register offsets, field positions, reset values and constants of the spectral alarm configuration bank
`ifndef SAB_MAP_VH
`define SAB_MAP_VH

`define SAB_ADDR_W          7
`define SAB_ADDR_LOWER_BIN  7'h20
`define SAB_ADDR_UPPER_BIN  7'h22
`define SAB_ADDR_X_ONE      7'h24
`define SAB_ADDR_Y_ONE      7'h26
`define SAB_ADDR_Z_ONE      7'h28
`define SAB_ADDR_X_TWO      7'h2A
`define SAB_ADDR_Y_TWO      7'h2C
`define SAB_ADDR_Z_TWO      7'h2E
`define SAB_ADDR_SELECTOR   7'h30

`define SAB_BIN_W           12
`define SAB_LEVEL_W         16
`define SAB_RESET_WORD      16'h0000
`define SAB_RESET_BIN       12'h000
`define SAB_RESET_SELECTOR  5'h00

`define SAB_SEL_RATE_HI     9
`define SAB_SEL_RATE_LO     8
`define SAB_SEL_BAND_HI     2
`define SAB_SEL_BAND_LO     0

`define SAB_NUM_RATES       4
`define SAB_NUM_BANDS       6
`define SAB_NUM_ENTRIES     24
`define SAB_BAND_FIRST      3'h1
`define SAB_BAND_LAST       3'h6

`define SAB_MODE_W          2
`define SAB_MODE_TIME       2'h0
`define SAB_MODE_MANUAL_FFT 2'h1
`define SAB_MODE_TIMED_FFT  2'h2

`define SAB_BASE_RATE_HZ    32'd220000
`define SAB_FFT_LOG2        4'hC
`define SAB_FREQ_W          17

`endif

// >>> sab_level_compare.v
// Per-axis two-level threshold comparator for one alarm evaluation
`timescale 1ns/1ps
`include "sab_map.vh"

module sab_level_compare (
  // Measured values per axis, x in low word
  input  wire [3*`SAB_LEVEL_W-1:0] measured,
  // Thresholds per axis, x in low word
  input  wire [3*`SAB_LEVEL_W-1:0] levelOne,
  input  wire [3*`SAB_LEVEL_W-1:0] levelTwo,
  // Qualifier for the whole evaluation
  input  wire                      allow,
  // Raised alarms per axis
  output wire [2:0]                hitOne,
  output wire [2:0]                hitTwo
);

  genvar a;
  generate
    for (a = 0; a < 3; a = a + 1) begin : gAxis
      wire [`SAB_LEVEL_W-1:0] val;
      assign val       = measured[a*`SAB_LEVEL_W +: `SAB_LEVEL_W];
      assign hitOne[a] = allow && (val > levelOne[a*`SAB_LEVEL_W +: `SAB_LEVEL_W]);
      assign hitTwo[a] = allow && (val > levelTwo[a*`SAB_LEVEL_W +: `SAB_LEVEL_W]);
    end
  endgenerate

endmodule // sab_level_compare

// >>> sab_config_bank.v
// Spectral alarm configuration bank with pointer window, rate rotation and alarm evaluation
`timescale 1ns/1ps
`include "sab_map.vh"

module sab_config_bank (
  // Clock, reset, enable
  input  wire                      clk,
  input  wire                      reset,
  input  wire                      ce,
  // Register port, byte writes, word reads
  input  wire                      regWrite,
  input  wire                      regRead,
  input  wire [`SAB_ADDR_W-1:0]    regAddr,
  input  wire [7:0]                regWrData,
  output reg  [15:0]               regRdData,
  output reg                       regRdValid,
  // Record control settings
  input  wire [`SAB_MODE_W-1:0]    recordMode,
  input  wire                      rootSumSquareCombine,
  input  wire [3:0]                rateEnable,
  input  wire [15:0]               decimationControl,
  // Capture and evaluation
  input  wire                      captureEvent,
  input  wire                      evalValid,
  input  wire [2:0]                evalBand,
  input  wire [`SAB_BIN_W-1:0]     evalBin,
  input  wire [`SAB_LEVEL_W-1:0]   evalX,
  input  wire [`SAB_LEVEL_W-1:0]   evalY,
  input  wire [`SAB_LEVEL_W-1:0]   evalZ,
  input  wire [`SAB_LEVEL_W-1:0]   evalRss,
  // Results
  output reg  [1:0]                captureRate,
  output reg  [2:0]                alarmOne,
  output reg  [2:0]                alarmTwo,
  output reg                       evalDone,
  output reg  [`SAB_FREQ_W-1:0]    upperBinFreqHz
);

  // Entry index of a rate and band
  function [4:0] entryIndex;
    input [1:0] rate;
    input [2:0] band;
    begin
      entryIndex = {1'b0, rate, 2'b00} + {2'b00, rate, 1'b0} + {2'b00, band} - 5'h01;
    end
  endfunction

  // First enabled rate at or after a start slot
  function [2:0] pickRate;
    input [1:0] start;
    input [3:0] enable;
    reg   [1:0] probe;
    integer     k;
    begin
      pickRate = 3'h0;
      probe    = start;
      for (k = 3; k >= 0; k = k - 1) begin
        probe = start + k[1:0];
        if (enable[probe]) begin
          pickRate = {1'b1, probe};
        end
      end
    end
  endfunction

  // Selector register
  reg  [1:0] selRate_r;
  reg  [2:0] selBand_r;
  wire       selValid;
  wire [4:0] selIdx;

  assign selValid = (selBand_r >= `SAB_BAND_FIRST) && (selBand_r <= `SAB_BAND_LAST);
  assign selIdx   = entryIndex(selRate_r, selBand_r);

  // Word address and byte lane of an access
  wire [`SAB_ADDR_W-1:0] wordAddr;
  wire                   highByte;
  wire                   wrSel;

  assign wordAddr = {regAddr[`SAB_ADDR_W-1:1], 1'b0};
  assign highByte = regAddr[0];
  assign wrSel    = ce && regWrite && (wordAddr == `SAB_ADDR_SELECTOR);

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      {selRate_r, selBand_r} <= `SAB_RESET_SELECTOR;
    end else if (wrSel) begin
      if (highByte) begin
        selRate_r <= regWrData[`SAB_SEL_RATE_HI-8:`SAB_SEL_RATE_LO-8];
      end else begin
        selBand_r <= regWrData[`SAB_SEL_BAND_HI:`SAB_SEL_BAND_LO];
      end
    end
  end

  // Alarm definition storage, one entry per rate and band
  reg [`SAB_BIN_W-1:0]   lowerMem [0:`SAB_NUM_ENTRIES-1];
  reg [`SAB_BIN_W-1:0]   upperMem [0:`SAB_NUM_ENTRIES-1];
  reg [`SAB_LEVEL_W-1:0] xOneMem  [0:`SAB_NUM_ENTRIES-1];
  reg [`SAB_LEVEL_W-1:0] yOneMem  [0:`SAB_NUM_ENTRIES-1];
  reg [`SAB_LEVEL_W-1:0] zOneMem  [0:`SAB_NUM_ENTRIES-1];
  reg [`SAB_LEVEL_W-1:0] xTwoMem  [0:`SAB_NUM_ENTRIES-1];
  reg [`SAB_LEVEL_W-1:0] yTwoMem  [0:`SAB_NUM_ENTRIES-1];
  reg [`SAB_LEVEL_W-1:0] zTwoMem  [0:`SAB_NUM_ENTRIES-1];

  wire wrWindow;
  assign wrWindow = ce && regWrite && selValid;

  genvar e;
  generate
    for (e = 0; e < `SAB_NUM_ENTRIES; e = e + 1) begin : gEntry
      wire hit;
      assign hit = wrWindow && (selIdx == e);
      always @(posedge clk or posedge reset) begin
        if (reset) begin
          lowerMem[e] <= `SAB_RESET_BIN;
          upperMem[e] <= `SAB_RESET_BIN;
          xOneMem[e]  <= `SAB_RESET_WORD;
          yOneMem[e]  <= `SAB_RESET_WORD;
          zOneMem[e]  <= `SAB_RESET_WORD;
          xTwoMem[e]  <= `SAB_RESET_WORD;
          yTwoMem[e]  <= `SAB_RESET_WORD;
          zTwoMem[e]  <= `SAB_RESET_WORD;
        end else if (hit) begin
          case (wordAddr)
            `SAB_ADDR_LOWER_BIN: begin
              if (highByte) lowerMem[e][11:8] <= regWrData[3:0];
              else          lowerMem[e][7:0]  <= regWrData;
            end
            `SAB_ADDR_UPPER_BIN: begin
              if (highByte) upperMem[e][11:8] <= regWrData[3:0];
              else          upperMem[e][7:0]  <= regWrData;
            end
            `SAB_ADDR_X_ONE: begin
              if (highByte) xOneMem[e][15:8] <= regWrData;
              else          xOneMem[e][7:0]  <= regWrData;
            end
            `SAB_ADDR_Y_ONE: begin
              if (highByte) yOneMem[e][15:8] <= regWrData;
              else          yOneMem[e][7:0]  <= regWrData;
            end
            `SAB_ADDR_Z_ONE: begin
              if (highByte) zOneMem[e][15:8] <= regWrData;
              else          zOneMem[e][7:0]  <= regWrData;
            end
            `SAB_ADDR_X_TWO: begin
              if (highByte) xTwoMem[e][15:8] <= regWrData;
              else          xTwoMem[e][7:0]  <= regWrData;
            end
            `SAB_ADDR_Y_TWO: begin
              if (highByte) yTwoMem[e][15:8] <= regWrData;
              else          yTwoMem[e][7:0]  <= regWrData;
            end
            `SAB_ADDR_Z_TWO: begin
              if (highByte) zTwoMem[e][15:8] <= regWrData;
              else          zTwoMem[e][7:0]  <= regWrData;
            end
            default: begin
              lowerMem[e] <= lowerMem[e];
            end
          endcase
        end
      end
    end
  endgenerate

  // Window view: the selected entry appears in the shared registers
  reg [15:0] readWord;

  always @* begin
    readWord = 16'h0000;
    case (wordAddr)
      `SAB_ADDR_SELECTOR: readWord = {6'h00, selRate_r, 5'h00, selBand_r};
      `SAB_ADDR_LOWER_BIN: if (selValid) readWord = {4'h0, lowerMem[selIdx]};
      `SAB_ADDR_UPPER_BIN: if (selValid) readWord = {4'h0, upperMem[selIdx]};
      `SAB_ADDR_X_ONE: if (selValid) readWord = xOneMem[selIdx];
      `SAB_ADDR_Y_ONE: if (selValid) readWord = yOneMem[selIdx];
      `SAB_ADDR_Z_ONE: if (selValid) readWord = zOneMem[selIdx];
      `SAB_ADDR_X_TWO: if (selValid) readWord = xTwoMem[selIdx];
      `SAB_ADDR_Y_TWO: if (selValid) readWord = yTwoMem[selIdx];
      `SAB_ADDR_Z_TWO: if (selValid) readWord = zTwoMem[selIdx];
      default: readWord = 16'h0000;
    endcase
  end

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      regRdData  <= 16'h0000;
      regRdValid <= 1'b0;
    end else if (ce) begin
      regRdValid <= regRead;
      if (regRead) begin
        regRdData <= readWord;
      end
    end
  end

  // Upper-bin frequency of the selected alarm
  wire [3:0]  selFactor;
  wire [31:0] freqProduct;
  wire [31:0] freqShifted;

  assign selFactor   = decimationControl[{selRate_r, 2'b00} +: 4];
  assign freqProduct = {20'h00000, (selValid ? upperMem[selIdx] : `SAB_RESET_BIN)} * `SAB_BASE_RATE_HZ;
  assign freqShifted = freqProduct >> ({1'b0, selFactor} + {1'b0, `SAB_FFT_LOG2});

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      upperBinFreqHz <= {`SAB_FREQ_W{1'b0}};
    end else if (ce) begin
      upperBinFreqHz <= freqShifted[`SAB_FREQ_W-1:0];
    end
  end

  // Rate rotation across capture events
  reg  [1:0] nextSlot_r;
  wire [2:0] picked;

  assign picked = pickRate(nextSlot_r, rateEnable);

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      nextSlot_r  <= 2'h0;
      captureRate <= 2'h0;
    end else if (ce && captureEvent && picked[2]) begin
      captureRate <= picked[1:0];
      nextSlot_r  <= picked[1:0] + 2'h1;
    end
  end

  // Alarm evaluation against the entry of the capture's rate
  wire                      evalBandOk;
  wire [4:0]                evalIdx;
  wire                      timeMode;
  wire                      spectralMode;
  wire                      inBand;
  wire                      allow;
  wire [`SAB_LEVEL_W-1:0]   zMeasured;
  wire [2:0]                hitOne;
  wire [2:0]                hitTwo;

  assign evalBandOk   = (evalBand >= `SAB_BAND_FIRST) && (evalBand <= `SAB_BAND_LAST);
  assign evalIdx      = evalBandOk ? entryIndex(captureRate, evalBand) : 5'h00;
  assign timeMode     = (recordMode == `SAB_MODE_TIME);
  assign spectralMode = (recordMode == `SAB_MODE_MANUAL_FFT) || (recordMode == `SAB_MODE_TIMED_FFT);
  assign inBand       = (evalBin >= lowerMem[evalIdx]) && (evalBin <= upperMem[evalIdx]);
  assign allow        = evalBandOk && (timeMode || (spectralMode && inBand));
  assign zMeasured    = (timeMode && rootSumSquareCombine) ? evalRss : evalZ;

  sab_level_compare uCompare (
    .measured (({zMeasured, evalY, evalX})),
    .levelOne (({zOneMem[evalIdx], yOneMem[evalIdx], xOneMem[evalIdx]})),
    .levelTwo (({zTwoMem[evalIdx], yTwoMem[evalIdx], xTwoMem[evalIdx]})),
    .allow    (allow),
    .hitOne   (hitOne),
    .hitTwo   (hitTwo)
  );

  always @(posedge clk or posedge reset) begin
    if (reset) begin
      alarmOne <= 3'h0;
      alarmTwo <= 3'h0;
      evalDone <= 1'b0;
    end else if (ce) begin
      evalDone <= evalValid;
      if (evalValid) begin
        alarmOne <= hitOne;
        alarmTwo <= hitTwo;
      end
    end
  end

endmodule // sab_config_bank

// >>> sab_config_bank_monitor.sv
// Port checker for the spectral alarm configuration bank
`timescale 1ns/1ps
module sab_config_bank_monitor (
  // Clock, reset, enable
  input wire        clk,
  input wire        reset,
  input wire        ce,
  // Register port
  input wire        regRead,
  input wire [6:0]  regAddr,
  input wire [15:0] regRdData,
  input wire        regRdValid,
  // Settings and capture
  input wire [1:0]  recordMode,
  input wire [3:0]  rateEnable,
  input wire        captureEvent,
  input wire [1:0]  captureRate,
  // Evaluation
  input wire        evalValid,
  input wire [2:0]  evalBand,
  input wire [15:0] evalX,
  input wire [15:0] evalY,
  input wire [15:0] evalZ,
  input wire [15:0] evalRss,
  input wire [2:0]  alarmOne,
  input wire [2:0]  alarmTwo,
  input wire        evalDone
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  wire evalGo = ce && evalValid;
  wire capGo  = ce && captureEvent && (rateEnable != 4'h0);
  property p_rdPulse; ce && !regRead |=> !regRdValid; endproperty
  a_rdPulse: assert property (p_rdPulse) else $error("read valid without request");
  property p_binTop; ce && regRead && regAddr[6:2] == 5'h08 |=> regRdValid && regRdData[15:12] == 4'h0; endproperty
  a_binTop: assert property (p_binTop) else $error("bin upper bits not zero");
  property p_selBits; ce && regRead && regAddr[6:1] == 6'h18 |=> regRdData[15:10] == 6'h00 && regRdData[7:3] == 5'h00;
  endproperty
  a_selBits: assert property (p_selBits) else $error("selector unused bits not zero");
  property p_done; evalGo |=> evalDone ##1 (!evalDone || $past(evalGo) || !$past(ce)); endproperty
  a_done: assert property (p_done) else $error("eval done missing");
  property p_hold; !evalGo |=> $stable(alarmOne) && $stable(alarmTwo); endproperty
  a_hold: assert property (p_hold) else $error("alarms changed without eval");
  property p_badBand; evalGo && (evalBand == 3'h0 || evalBand == 3'h7) |=> alarmOne == 3'h0 && alarmTwo == 3'h0;
  endproperty
  a_badBand: assert property (p_badBand) else $error("alarm on invalid band");
  property p_noMode; evalGo && recordMode == 2'h3 |=> alarmOne == 3'h0 && alarmTwo == 3'h0; endproperty
  a_noMode: assert property (p_noMode) else $error("alarm with no mode");
  property p_zero; evalGo && {evalX, evalY, evalZ, evalRss} == 64'h0 |=> alarmOne == 3'h0 && alarmTwo == 3'h0;
  endproperty
  a_zero: assert property (p_zero) else $error("alarm on zero magnitude");
  property p_oneRate; capGo && rateEnable == 4'h8 |=> captureRate == 2'h3; endproperty
  a_oneRate: assert property (p_oneRate) else $error("single rate not used");
  property p_rateHold; !capGo |=> $stable(captureRate); endproperty
  a_rateHold: assert property (p_rateHold) else $error("rate changed without capture");
  c_multi: cover property (capGo && rateEnable == 4'hF);
  c_two: cover property (evalGo ##1 alarmTwo != 3'h0);
  c_sel: cover property (ce && regRead && regAddr == 7'h30);
endmodule // sab_config_bank_monitor

bind sab_config_bank sab_config_bank_monitor i_sab_config_bank_monitor (.clk(clk), .reset(reset), .ce(ce),
  .regRead(regRead), .regAddr(regAddr), .regRdData(regRdData), .regRdValid(regRdValid), .recordMode(recordMode),
  .rateEnable(rateEnable), .captureEvent(captureEvent), .captureRate(captureRate), .evalValid(evalValid),
  .evalBand(evalBand), .evalX(evalX), .evalY(evalY), .evalZ(evalZ), .evalRss(evalRss), .alarmOne(alarmOne),
  .alarmTwo(alarmTwo), .evalDone(evalDone));

// >>> sab_host_model.sv
// Host model driving the byte-wide register port
`timescale 1ns/1ps
module sab_host_model (
  // Clock
  input  wire        clk,
  // Register port
  output reg         regWrite,
  output reg         regRead,
  output reg  [6:0]  regAddr,
  output reg  [7:0]  regWrData,
  input  wire [15:0] regRdData,
  input  wire        regRdValid
);
  initial begin
    regWrite = 1'b0;
    regRead = 1'b0;
    regAddr = 7'h7F;
    regWrData = 8'h00;
  end
  // Released lines show the inverse of their last value
  task wrByte(input [6:0] a, input [7:0] d);
    begin
      @(posedge clk) #1;
      regWrite = 1'b1;
      regAddr = a;
      regWrData = d;
      @(posedge clk) #1;
      regWrite = 1'b0;
      regAddr = ~a;
      regWrData = ~d;
    end
  endtask
  task wrWord(input [6:0] a, input [15:0] w);
    begin
      wrByte(a, w[7:0]);
      wrByte(a | 7'h01, w[15:8]);
    end
  endtask
  task rdWord(input [6:0] a, output [15:0] w, output ok);
    begin
      @(posedge clk) #1;
      regRead = 1'b1;
      regAddr = a;
      @(posedge clk) #1;
      regRead = 1'b0;
      regAddr = ~a;
      ok = regRdValid;
      w = regRdData;
    end
  endtask
endmodule // sab_host_model

// >>> sab_config_bank_tb.sv
// Self-checking testbench for the spectral alarm configuration bank
`timescale 1ns/1ps
`include "sab_map.vh"
module sab_config_bank_tb;
  reg         clk, reset, ce, root_sum_square_combine, captureEvent, evalValid, ok, inr;
  reg  [1:0]  recordMode;
  reg  [3:0]  rateEnable;
  reg  [15:0] decim, evalX, evalY, evalZ, evalRss, w, zv, mem [0:191];
  reg  [2:0]  evalBand, e1, e2;
  reg  [11:0] evalBin;
  wire        regWrite, regRead, regRdValid, evalDone;
  wire [6:0]  regAddr;
  wire [7:0]  regWrData;
  wire [15:0] regRdData;
  wire [1:0]  captureRate;
  wire [2:0]  alarmOne, alarmTwo;
  wire [16:0] upperBinFreqHz;
  integer     nErrors, checked, cyc, i, k, r, b, kk, slot;
  sab_config_bank i_sab_config_bank (.clk(clk), .reset(reset), .ce(ce), .regWrite(regWrite), .regRead(regRead),
    .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData), .regRdValid(regRdValid),
    .recordMode(recordMode), .rootSumSquareCombine(root_sum_square_combine), .rateEnable(rateEnable), .decimationControl(decim),
    .captureEvent(captureEvent), .evalValid(evalValid), .evalBand(evalBand), .evalBin(evalBin), .evalX(evalX),
    .evalY(evalY), .evalZ(evalZ), .evalRss(evalRss), .captureRate(captureRate), .alarmOne(alarmOne),
    .alarmTwo(alarmTwo), .evalDone(evalDone), .upperBinFreqHz(upperBinFreqHz));
  sab_host_model i_sab_host_model (.clk(clk), .regWrite(regWrite), .regRead(regRead), .regAddr(regAddr),
    .regWrData(regWrData), .regRdData(regRdData), .regRdValid(regRdValid));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      nErrors = nErrors + 1;
      completeRun;
    end
  end
  function integer key(input integer rr, input integer bb);
    key = (rr * 6 + bb - 1) * 8;
  endfunction
  function [6:0] ad(input integer n);
    ad = 7'h20 + {n[5:0], 1'b0};
  endfunction
  task chk(input [31:0] seen, input [31:0] exp, input string name);
    begin
      checked = checked + 1;
      if (seen !== exp) begin
        nErrors = nErrors + 1;
        $display("Error %s expected %h seen %h", name, exp, seen);
      end
    end
  endtask
  task rdChk(input [6:0] a, input [15:0] e, input string name);
    begin
      i_sab_host_model.rdWord(a, w, ok);
      chk(ok, 1'b1, "readValid");
      chk(w, e, name);
    end
  endtask
  task sel(input [1:0] rr, input [2:0] bb);
    i_sab_host_model.wrWord(7'h30, {6'h00, rr, 5'h00, bb});
  endtask
  task capture(input [3:0] en);
    begin
      @(posedge clk) #1;
      rateEnable = en;
      captureEvent = 1'b1;
      @(posedge clk) #1;
      captureEvent = 1'b0;
      if (en != 4'h0) begin
        while (!en[slot]) slot = (slot + 1) % 4;
        chk(captureRate, slot, "captureRate");
        slot = (slot + 1) % 4;
      end
    end
  endtask
  task completeRun;
    begin
      $display("comparisons %0d mismatches %0d", checked, nErrors);
      if (nErrors == 0 && checked > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  initial begin
    {reset, ce, root_sum_square_combine, captureEvent, evalValid, recordMode, rateEnable, evalBand, evalBin} = 0;
    {evalX, evalY, evalZ, evalRss} = 64'h0;
    {nErrors, checked, cyc, slot} = 0;
    decim = 16'h7421;
    w = $urandom(32'h175C);
    reset = 1'b1;
    repeat (16) @(posedge clk);
    #1 reset = 1'b0;
    ce = 1'b1;
    for (k = 0; k < 9; k = k + 1) rdChk(ad(k), 16'h0000, "resetValue");
    rdChk(7'h40, 16'h0000, "unmapped");
    i_sab_host_model.wrWord(7'h24, 16'hBEEF);
    sel(2'h0, 3'h1);
    rdChk(7'h24, 16'h0000, "refusedWrite");
    $display("test reset done");
    for (r = 0; r < 4; r = r + 1)
      for (b = 1; b < 7; b = b + 1) begin
        sel(r, b);
        for (k = 0; k < 8; k = k + 1) begin
          w = $urandom;
          if (k > 4) w = w | mem[key(r, b) + k - 3];
          mem[key(r, b) + k] = w & (k < 2 ? 16'h0FFF : 16'hFFFF);
          i_sab_host_model.wrWord(ad(k), w);
        end
      end
    for (r = 3; r >= 0; r = r - 1)
      for (b = 1; b < 7; b = b + 1) begin
        sel(r, b);
        for (k = 0; k < 8; k = k + 1) rdChk(ad(k), mem[key(r, b) + k], "window");
      end
    i_sab_host_model.wrWord(7'h30, 16'hFFFF);
    rdChk(7'h30, 16'h0307, "selector");
    rdChk(7'h22, 16'h0000, "badBandWindow");
    ce = 1'b0;
    i_sab_host_model.wrWord(7'h30, 16'h0001);
    ce = 1'b1;
    rdChk(7'h30, 16'h0307, "frozenSelector");
    $display("test window done");
    for (i = 0; i < 8; i = i + 1) begin
      r = $urandom % 4;
      b = 1 + $urandom % 6;
      decim = {4'($urandom % 7 + 1), 4'($urandom % 7 + 1), 4'($urandom % 7 + 1), 4'($urandom % 7 + 1)};
      sel(r, b);
      kk = ({48'h0, mem[key(r, b) + 1]} * `SAB_BASE_RATE_HZ) >> (decim[4 * r +: 4] + 12);
      repeat (2) @(posedge clk);
      #1 chk(upperBinFreqHz, kk, "frequency");
    end
    $display("test frequency done");
    capture(4'h5);
    capture(4'h5);
    capture(4'h0);
    for (i = 0; i < 10; i = i + 1) capture(i < 5 ? 4'hF : $urandom);
    $display("test rotation done");
    for (i = 0; i < 120; i = i + 1) begin
      r = $urandom % 4;
      capture(4'h1 << r);
      recordMode = $urandom;
      root_sum_square_combine = $urandom;
      evalBand = $urandom;
      kk = key(r, (evalBand == 3'h0 || evalBand == 3'h7) ? 1 : evalBand);
      case ($urandom % 4)
        0: evalBin = mem[kk];
        1: evalBin = mem[kk + 1];
        2: evalBin = mem[kk + 1] + 12'h001;
        default: evalBin = $urandom % 2048;
      endcase
      {evalX, evalY, evalZ, evalRss} = {$urandom, $urandom};
      if (i == 0) {evalX, evalY, evalZ, evalRss} = 64'h0;
      inr = recordMode == 2'h0 || (evalBin >= mem[kk] && evalBin <= mem[kk + 1]);
      zv = (recordMode == 2'h0 && root_sum_square_combine) ? evalRss : evalZ;
      e1 = {zv > mem[kk + 4], evalY > mem[kk + 3], evalX > mem[kk + 2]} & {3{inr}};
      e2 = {zv > mem[kk + 7], evalY > mem[kk + 6], evalX > mem[kk + 5]} & {3{inr}};
      if (evalBand == 3'h0 || evalBand == 3'h7 || recordMode == 2'h3) {e1, e2} = 6'h00;
      evalValid = 1'b1;
      @(posedge clk) #1;
      evalValid = 1'b0;
      chk(evalDone, 1'b1, "evalDone");
      chk(alarmOne, e1, "alarmOne");
      chk(alarmTwo, e2, "alarmTwo");
    end
    $display("test evaluation done");
    completeRun;
  end
endmodule // sab_config_bank_tb
